// file: bps_pin_seq.sv
// Purpose: reset pin states, page toggling, bus lock and flag pin control
// Assumes: core signals are synchronous to clk_i; one clk_i per phase half
// Notes:   pins are split into value and enable; the bench resolves wires
// Operation
// - while reset is held all data lines of both buses and the link lanes float, from a primary phase rise.
// - while reset is held both address buses float, from a secondary phase rise.
// - during reset strobes, status, lock and read/write go high and both page selects of each bus go low.
// - during reset the interrupt acknowledge goes to its inactive high level from a primary phase rise.
// - reset going low floats the timer clock pins, the flag pins and the link handshake pins at once.
// - reset returning high drives the local handshake lines of every link port high.
// - reset makes link ports zero to two outputs and ports three to five inputs.
// - reset is taken asynchronously, synchronised, and a missed edge delays the sequence by one cycle.
// - an access to a different page than the last one toggles that page select at a primary phase fall.
// - a flag pin set as output drives the stored flag value, updated in the execute phase of the write.
// - a flag pin turned from input to output starts driving after the primary phase falls.
// - a flag pin turned from output to input stops driving and is then sampled on later primary falls.
// - the interlocked signal operation asserts lock around its access and releases it, both at primary falls.
// - an interlocked store releases lock after its access at a primary fall.
// - an interlocked load asserts lock with its access, holding other masters off until the store.
module bps_pin_seq
  import bps_pkg::*;
(
  // clock and reset
  input  wire logic                                     clk_i,
  input  wire logic                                     resetn_i,
  // phases and reset state to the core
  output logic                                          primary_phase_o,
  output logic                                          secondary_phase_o,
  output logic                                          reset_active_o,
  // core access per bus
  input  wire logic [NUM_BUS-1:0]                       core_acc_i,
  input  wire logic [NUM_BUS-1:0][ADDR_W-1:0]           core_addr_i,
  input  wire logic [NUM_BUS-1:0][DATA_W-1:0]           core_wdata_i,
  input  wire logic [NUM_BUS-1:0]                       core_data_drive_i,
  input  wire logic [NUM_BUS-1:0][1:0]                  core_rw_i,
  input  wire logic [NUM_BUS-1:0][1:0]                  core_strb_n_i,
  input  wire logic [NUM_BUS-1:0][STAT_W-1:0]           core_stat_i,
  input  wire logic [NUM_BUS-1:0][PAGE_W-1:0]           core_page_i,
  input  wire logic [NUM_BUS-1:0]                       core_page_sel_i,
  input  wire bps_lock_op_t                             core_lock_op_i,
  input  wire logic                                     core_interrupt_ack_out_n_i,
  // external bus pins
  output logic [NUM_BUS-1:0][DATA_W-1:0]                bus_data_lines_o,
  output logic [NUM_BUS-1:0]                            bus_data_lines_oe_o,
  output logic [NUM_BUS-1:0][ADDR_W-1:0]                bus_address_lines_o,
  output logic [NUM_BUS-1:0]                            bus_address_lines_oe_o,
  output logic [NUM_BUS-1:0][1:0]                       bus_strobe_n_o,
  output logic [NUM_BUS-1:0][STAT_W-1:0]                bus_status_lines_o,
  output logic [NUM_BUS-1:0][1:0]                       bus_read_write_o,
  output logic [NUM_BUS-1:0]                            page_select_a_o,
  output logic [NUM_BUS-1:0]                            page_select_b_o,
  output logic [NUM_BUS-1:0]                            bus_lock_n_o,
  output logic                                          interrupt_ack_out_n_o,
  // interrupt flag pins and register
  input  wire logic                                     flag_we_i,
  input  wire logic [NUM_FLAG-1:0]                      flag_dir_i,
  input  wire logic [NUM_FLAG-1:0]                      flag_val_i,
  input  wire logic [NUM_FLAG-1:0]                      interrupt_flag_pin_i,
  output logic [NUM_FLAG-1:0]                           interrupt_flag_pin_o,
  output logic [NUM_FLAG-1:0]                           interrupt_flag_pin_oe_o,
  output logic [NUM_FLAG-1:0]                           flag_sample_o,
  // timer clock pins
  input  wire logic [1:0]                               core_tclk_i,
  input  wire logic [1:0]                               core_tclk_oe_i,
  output logic                                          timer_clock_pin_a_o,
  output logic                                          timer_clock_pin_a_oe_o,
  output logic                                          timer_clock_pin_b_o,
  output logic                                          timer_clock_pin_b_oe_o,
  // link ports
  input  wire logic                                     core_link_dir_we_i,
  input  wire logic [NUM_LINK-1:0]                      core_link_dir_i,
  input  wire logic [NUM_LINK-1:0][7:0]                 core_link_data_i,
  input  wire logic [NUM_LINK-1:0][LINK_LINES-1:0]      core_link_hs_i,
  input  wire logic [NUM_LINK-1:0][LINK_LINES-1:0]      core_link_hs_oe_i,
  output logic [NUM_LINK-1:0]                           link_dir_o,
  output logic [NUM_LINK-1:0][7:0]                      link_port_byte_lane_o,
  output logic [NUM_LINK-1:0]                           link_port_byte_lane_oe_o,
  output logic [NUM_LINK-1:0][LINK_LINES-1:0]           link_hs_o,
  output logic [NUM_LINK-1:0][LINK_LINES-1:0]           link_hs_oe_o
);

  typedef struct packed {
    bps_state_t                           st;
    logic                                 ph;
    logic [NUM_BUS-1:0]                   data_oe;
    logic [NUM_BUS-1:0][DATA_W-1:0]       data;
    logic [NUM_BUS-1:0]                   addr_oe;
    logic [NUM_BUS-1:0][ADDR_W-1:0]       addr;
    logic [NUM_BUS-1:0][1:0]              strb_n;
    logic [NUM_BUS-1:0][STAT_W-1:0]       stat;
    logic [NUM_BUS-1:0][1:0]              rw;
    logic [NUM_BUS-1:0]                   page_a;
    logic [NUM_BUS-1:0]                   page_b;
    logic [NUM_BUS-1:0][PAGE_W-1:0]       last_a;
    logic [NUM_BUS-1:0][PAGE_W-1:0]       last_b;
    logic [NUM_BUS-1:0]                   lock_n;
    bps_lock_t [NUM_BUS-1:0]              lk;
    logic                                 interrupt_ack_out_n;
    logic                                 flag_pend;
    logic [NUM_FLAG-1:0]                  pend_dir;
    logic [NUM_FLAG-1:0]                  pend_val;
    logic [NUM_FLAG-1:0]                  flag_dir;
    logic [NUM_FLAG-1:0]                  flag_val;
    logic [NUM_FLAG-1:0]                  flag_in;
    logic [NUM_LINK-1:0]                  link_dir;
    logic [NUM_LINK-1:0][7:0]             link_data;
  } bps_core_st_t;

  localparam bps_core_st_t ST_RST = '{
    st:        BPS_ST_RESET,
    ph:        1'b0,
    data_oe:   '0,
    data:      '0,
    addr_oe:   '0,
    addr:      '0,
    strb_n:    {NUM_BUS{STRB_RST}},
    stat:      {NUM_BUS{STAT_RST}},
    rw:        {NUM_BUS{RW_RST}},
    page_a:    {NUM_BUS{PAGE_RST}},
    page_b:    {NUM_BUS{PAGE_RST}},
    last_a:    '0,
    last_b:    '0,
    lock_n:    {NUM_BUS{LOCK_RST}},
    lk:        {NUM_BUS{BPS_LK_IDLE}},
    interrupt_ack_out_n:    INTERRUPT_ACK_OUT_RST,
    flag_pend: 1'b0,
    pend_dir:  '0,
    pend_val:  '0,
    flag_dir:  '0,
    flag_val:  '0,
    flag_in:   '0,
    link_dir:  LINK_DIR_RST,
    link_data: '0
  };

  bps_core_st_t st_r;
  bps_core_st_t st_nxt;
  logic         released;
  logic         h1_rise;
  logic         h1_fall;
  logic         run;

  bps_reset_sync u_sync (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .released_o (released)
  );

  // ph high is the primary phase; secondary rises as primary falls
  assign h1_rise = !st_r.ph;
  assign h1_fall = st_r.ph;
  assign run     = (st_r.st == BPS_ST_RUN);

  always_comb begin
    st_nxt    = st_r;
    st_nxt.ph = !st_r.ph;

    case (st_r.st)
      BPS_ST_RESET: begin
        // relies on the source holding reset long enough to settle all pins
        if (released && h1_fall) begin
          st_nxt.st = BPS_ST_RUN;
        end
      end
      BPS_ST_RUN: begin
        st_nxt.st = BPS_ST_RUN;
      end
      default: begin
        st_nxt.st = BPS_ST_RESET;
      end
    endcase

    if (!run) begin
      if (h1_rise) begin
        st_nxt.data_oe = '0;
        st_nxt.interrupt_ack_out_n  = INTERRUPT_ACK_OUT_RST;
      end
      if (h1_fall) begin
        st_nxt.addr_oe = '0;
        st_nxt.strb_n  = {NUM_BUS{STRB_RST}};
        st_nxt.stat    = {NUM_BUS{STAT_RST}};
        st_nxt.rw      = {NUM_BUS{RW_RST}};
        st_nxt.lock_n  = {NUM_BUS{LOCK_RST}};
        st_nxt.page_a  = {NUM_BUS{PAGE_RST}};
        st_nxt.page_b  = {NUM_BUS{PAGE_RST}};
      end
      st_nxt.lk        = {NUM_BUS{BPS_LK_IDLE}};
      st_nxt.flag_dir  = '0;
      st_nxt.flag_pend = 1'b0;
      st_nxt.link_dir  = LINK_DIR_RST;
      st_nxt.link_data = '0;
    end else begin
      if (h1_fall) begin
        st_nxt.interrupt_ack_out_n = core_interrupt_ack_out_n_i;
      end
      st_nxt.link_data = core_link_data_i;
      if (core_link_dir_we_i) begin
        st_nxt.link_dir = core_link_dir_i;
      end

      for (int b = 0; b < NUM_BUS; b++) begin
        st_nxt.strb_n[b]  = core_strb_n_i[b];
        st_nxt.stat[b]    = core_stat_i[b];
        st_nxt.rw[b]      = core_rw_i[b];
        st_nxt.addr_oe[b] = 1'b1;
        st_nxt.data_oe[b] = core_data_drive_i[b];
        if (core_acc_i[b]) begin
          st_nxt.addr[b] = core_addr_i[b];
          st_nxt.data[b] = core_wdata_i[b];
        end

        if (h1_fall && core_acc_i[b]) begin
          if (!core_page_sel_i[b] && core_page_i[b] != st_r.last_a[b]) begin
            st_nxt.page_a[b] = !st_r.page_a[b];
            st_nxt.last_a[b] = core_page_i[b];
          end
          if (core_page_sel_i[b] && core_page_i[b] != st_r.last_b[b]) begin
            st_nxt.page_b[b] = !st_r.page_b[b];
            st_nxt.last_b[b] = core_page_i[b];
          end
        end

        // lock moves only on primary falls
        if (h1_fall) begin
          case (st_r.lk[b])
            BPS_LK_IDLE, BPS_LK_HELD: begin
              if (core_acc_i[b]) begin
                case (core_lock_op_i)
                  BPS_OP_LOAD: begin
                    st_nxt.lock_n[b] = 1'b0;
                    st_nxt.lk[b]     = BPS_LK_HELD;
                  end
                  BPS_OP_STORE: begin
                    st_nxt.lk[b] = BPS_LK_RELEASE;
                  end
                  BPS_OP_SIGNAL: begin
                    st_nxt.lock_n[b] = 1'b0;
                    st_nxt.lk[b]     = BPS_LK_RELEASE;
                  end
                  default: begin
                    st_nxt.lk[b] = st_r.lk[b];
                  end
                endcase
              end
            end
            BPS_LK_RELEASE: begin
              st_nxt.lock_n[b] = 1'b1;
              st_nxt.lk[b]     = BPS_LK_IDLE;
            end
            default: begin
              st_nxt.lk[b] = BPS_LK_IDLE;
            end
          endcase
        end
      end

      // a write waits for the next primary fall, its execute phase
      if (flag_we_i) begin
        st_nxt.flag_pend = 1'b1;
        st_nxt.pend_dir  = flag_dir_i;
        st_nxt.pend_val  = flag_val_i;
      end
      if (h1_fall) begin
        for (int f = 0; f < NUM_FLAG; f++) begin
          if (!st_r.flag_dir[f]) begin
            st_nxt.flag_in[f] = interrupt_flag_pin_i[f];
          end
        end
        if (st_r.flag_pend) begin
          st_nxt.flag_dir  = st_r.pend_dir;
          st_nxt.flag_val  = st_r.pend_val;
          st_nxt.flag_pend = flag_we_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign primary_phase_o   = st_r.ph;
  assign secondary_phase_o = !st_r.ph;
  assign reset_active_o    = !run;

  assign bus_data_lines_o       = st_r.data;
  assign bus_data_lines_oe_o    = st_r.data_oe;
  assign bus_address_lines_o    = st_r.addr;
  assign bus_address_lines_oe_o = st_r.addr_oe;
  assign bus_strobe_n_o         = st_r.strb_n;
  assign bus_status_lines_o     = st_r.stat;
  assign bus_read_write_o       = st_r.rw;
  assign page_select_a_o        = st_r.page_a;
  assign page_select_b_o        = st_r.page_b;
  assign bus_lock_n_o           = st_r.lock_n;
  assign interrupt_ack_out_n_o  = st_r.interrupt_ack_out_n;

  // async enables: these pins float the instant reset falls, no clock needed
  assign interrupt_flag_pin_o    = st_r.flag_val;
  assign interrupt_flag_pin_oe_o = {NUM_FLAG{resetn_i & run}} & st_r.flag_dir;
  assign flag_sample_o           = st_r.flag_in;

  assign timer_clock_pin_a_o    = core_tclk_i[0];
  assign timer_clock_pin_b_o    = core_tclk_i[1];
  assign timer_clock_pin_a_oe_o = resetn_i & run & core_tclk_oe_i[0];
  assign timer_clock_pin_b_oe_o = resetn_i & run & core_tclk_oe_i[1];

  assign link_dir_o = st_r.link_dir;

  for (genvar p = 0; p < NUM_LINK; p++) begin : g_link
    localparam logic [LINK_LINES-1:0] LOCAL_MASK = (p < 3) ? LINK_LOCAL_OUTPORT : LINK_LOCAL_INPORT;
    assign link_port_byte_lane_o[p]    = st_r.link_data[p];
    assign link_port_byte_lane_oe_o[p] = run & st_r.link_dir[p];
    // local lines go high asynchronously on release, core takes over after
    assign link_hs_o[p]    = run ? core_link_hs_i[p] : LOCAL_MASK;
    assign link_hs_oe_o[p] = {LINK_LINES{resetn_i}} &
                             (run ? core_link_hs_oe_i[p] : LOCAL_MASK);
  end

endmodule : bps_pin_seq

// file: bps_pkg.sv
// Purpose: shared constants and types for the bus pin reset and lock sequencer
// Assumes: 50 MHz clk_i; primary phase is clk_i divided by two
// Notes:   widths and reset pin states live here so all files agree
package bps_pkg;

  localparam int unsigned NUM_BUS    = 2;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 31;
  localparam int unsigned STAT_W     = 4;
  localparam int unsigned PAGE_W     = 8;
  localparam int unsigned NUM_LINK   = 6;
  localparam int unsigned NUM_FLAG   = 4;
  localparam int unsigned LINK_LINES = 4;

  // clock and reset timing
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned MIN_RESET_H1    = 10;
  localparam int unsigned H1_CLKS         = 2;
  localparam int unsigned MIN_RESET_CLKS  = MIN_RESET_H1 * H1_CLKS;

  // link port direction after reset: 1 = output; ports 0..2 out, 3..5 in
  localparam logic [NUM_LINK-1:0] LINK_DIR_RST = 6'h07;

  // handshake line order per port: {ready, strobe, ack, request}
  localparam logic [LINK_LINES-1:0] LINK_LOCAL_OUTPORT = 4'h6;
  localparam logic [LINK_LINES-1:0] LINK_LOCAL_INPORT  = 4'h9;

  // reset pin levels
  localparam logic [1:0]        STRB_RST = 2'h3;
  localparam logic [STAT_W-1:0] STAT_RST = 4'hf;
  localparam logic [1:0]        RW_RST   = 2'h3;
  localparam logic              PAGE_RST = 1'b0;
  localparam logic              LOCK_RST = 1'b1;
  localparam logic              INTERRUPT_ACK_OUT_RST = 1'b1;

  typedef enum logic [1:0] {
    BPS_ST_RESET = 2'b01,
    BPS_ST_RUN   = 2'b10
  } bps_state_t;

  typedef enum logic [2:0] {
    BPS_LK_IDLE    = 3'b001,
    BPS_LK_HELD    = 3'b010,
    BPS_LK_RELEASE = 3'b100
  } bps_lock_t;

  // interlocked operation presented with an external access
  typedef enum logic [3:0] {
    BPS_OP_NONE   = 4'b0001,
    BPS_OP_LOAD   = 4'b0010,
    BPS_OP_STORE  = 4'b0100,
    BPS_OP_SIGNAL = 4'b1000
  } bps_lock_op_t;

endpackage : bps_pkg

// file: bps_reset_sync.sv
// Purpose: two-stage synchroniser for the release of the asynchronous reset
// Assumes: resetn_i may change at any point of a clk_i period
// Notes:   assertion acts at once, release is seen two edges later
module bps_reset_sync
  import bps_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // synchronised release
  output logic      released_o
);

  typedef struct packed {
    logic s1;
    logic s2;
  } bps_sync_st_t;

  bps_sync_st_t st_r;
  bps_sync_st_t st_nxt;

  // a release missing the edge lands one cycle later
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = 1'b1;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign released_o = st_r.s2;

endmodule : bps_reset_sync

// file: bps_pin_seq_props.sv
// Purpose: concurrent checks on the pin sequencer ports
// Assumes: one clock domain; resetn_i async active low
// Notes:   lock checks watch bus 0, where the bench runs its interlocked ops
module bps_pin_seq_props
  import bps_pkg::*;
(
  // clock and reset
  input wire logic                                clk_i,
  input wire logic                                resetn_i,
  // core side
  input wire logic                                primary_phase_o,
  input wire logic                                reset_active_o,
  input wire logic [NUM_BUS-1:0]                  core_acc_i,
  input wire logic [NUM_BUS-1:0]                  core_page_sel_i,
  input wire bps_lock_op_t                        core_lock_op_i,
  // pins
  input wire logic [NUM_BUS-1:0]                  bus_data_lines_oe_o,
  input wire logic [NUM_BUS-1:0]                  bus_address_lines_oe_o,
  input wire logic [NUM_BUS-1:0][1:0]             bus_strobe_n_o,
  input wire logic [NUM_BUS-1:0][STAT_W-1:0]      bus_status_lines_o,
  input wire logic [NUM_BUS-1:0][1:0]             bus_read_write_o,
  input wire logic [NUM_BUS-1:0]                  page_select_a_o,
  input wire logic [NUM_BUS-1:0]                  page_select_b_o,
  input wire logic [NUM_BUS-1:0]                  bus_lock_n_o,
  input wire logic                                interrupt_ack_out_n_o,
  input wire logic [NUM_LINK-1:0]                 link_dir_o,
  input wire logic [NUM_LINK-1:0]                 link_port_byte_lane_oe_o,
  input wire logic [NUM_LINK-1:0][LINK_LINES-1:0] link_hs_o,
  input wire logic [NUM_LINK-1:0][LINK_LINES-1:0] link_hs_oe_o
);
  localparam logic [NUM_LINK-1:0][LINK_LINES-1:0] HS_MASK = {{3{LINK_LOCAL_INPORT}}, {3{LINK_LOCAL_OUTPORT}}};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_op(bps_lock_op_t op);
    !reset_active_o && primary_phase_o && core_acc_i[0] && core_lock_op_i == op;
  endsequence
  // lock low for two samples, then released at the next primary fall
  sequence s_pulse;
    !bus_lock_n_o[0] [*2] ##1 bus_lock_n_o[0];
  endsequence

  rst_float_a: assert property (reset_active_o |-> bus_data_lines_oe_o == '0 &&
    bus_address_lines_oe_o == '0 && link_port_byte_lane_oe_o == '0) else $error("bus floats wrong in reset");
  rst_ctrl_a: assert property (reset_active_o |-> bus_strobe_n_o == '1 && bus_status_lines_o == '1 &&
    bus_read_write_o == '1 && page_select_a_o == '0 && page_select_b_o == '0 && bus_lock_n_o == '1 &&
    interrupt_ack_out_n_o) else $error("control pins wrong in reset");
  hs_local_a: assert property (reset_active_o && resetn_i |-> link_hs_oe_o == HS_MASK &&
    (link_hs_o & HS_MASK) == HS_MASK) else $error("local handshake not high");
  link_dir_a: assert property (reset_active_o |-> link_dir_o == LINK_DIR_RST)
    else $error("link direction wrong in reset");
  sync_rel_a: assert property ($rose(resetn_i) |-> reset_active_o [*2] ##[1:3] !reset_active_o)
    else $error("reset release timing wrong");
  page_step_a: assert property (!reset_active_o && $changed(page_select_a_o[0]) |->
    $past(primary_phase_o) && $past(core_acc_i[0]) && !$past(core_page_sel_i[0])) else $error("page select moved alone");
  lock_sig_a: assert property (s_op(BPS_OP_SIGNAL) ##0 bus_lock_n_o[0] |-> ##1 s_pulse)
    else $error("signal lock pulse wrong");
  lock_store_a: assert property (s_op(BPS_OP_STORE) ##0 !bus_lock_n_o[0] |-> ##1 s_pulse)
    else $error("store lock release wrong");
  lock_load_a: assert property (s_op(BPS_OP_LOAD) ##0 bus_lock_n_o[0] |-> ##1 !bus_lock_n_o[0] [*2])
    else $error("load lock not held");
endmodule : bps_pin_seq_props

bind bps_pin_seq bps_pin_seq_props i_props (.*);

// file: bps_ext_model.sv
// Purpose: far side of the pins: reset source and external flag drivers
// Assumes: clk_i is the bench clock
// Notes:   reset asserts at once; release only after the minimum hold
module bps_ext_model
  import bps_pkg::*;
(
  // clock and reset request
  input  wire logic                clk_i,
  input  wire logic                rst_req_i,
  // flag wires
  input  wire logic [NUM_FLAG-1:0] ext_drv_i,
  input  wire logic [NUM_FLAG-1:0] pin_o_i,
  input  wire logic [NUM_FLAG-1:0] pin_oe_i,
  output logic                     resetn_o,
  output logic [NUM_FLAG-1:0]      pin_i_o
);
  int cnt;

  // short requests are stretched so the hold time is never cut
  always @(posedge clk_i or posedge rst_req_i) begin
    if (rst_req_i) begin
      cnt <= 0;
    end else if (cnt < MIN_RESET_CLKS) begin
      cnt <= cnt + 1;
    end
  end
  assign resetn_o = !rst_req_i && cnt >= MIN_RESET_CLKS;
  // an undriven pin shows the outside world, not the last driven value
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_drv_i);
endmodule : bps_ext_model

// file: bps_pin_seq_tb_top.sv
// Purpose: self-checking bench for the pin sequencer
// Assumes: partner model supplies reset and flag wires
// Notes:   page and follow expectations come from a bench model
module bps_pin_seq_tb_top
  import bps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic resetn_i, flag_we_i, core_link_dir_we_i, core_interrupt_ack_out_n_i, primary_phase_o, secondary_phase_o;
  logic reset_active_o, interrupt_ack_out_n_o, timer_clock_pin_a_o, timer_clock_pin_a_oe_o;
  logic timer_clock_pin_b_o, timer_clock_pin_b_oe_o;
  logic [NUM_BUS-1:0] core_acc_i, core_data_drive_i, core_page_sel_i, bus_data_lines_oe_o;
  logic [NUM_BUS-1:0] bus_address_lines_oe_o, page_select_a_o, page_select_b_o, bus_lock_n_o;
  logic [NUM_BUS-1:0][ADDR_W-1:0] core_addr_i, bus_address_lines_o;
  logic [NUM_BUS-1:0][DATA_W-1:0] core_wdata_i, bus_data_lines_o;
  logic [NUM_BUS-1:0][1:0] core_rw_i, core_strb_n_i, bus_strobe_n_o, bus_read_write_o, p_strb, p_rw;
  logic [NUM_BUS-1:0][STAT_W-1:0] core_stat_i, bus_status_lines_o, p_stat;
  logic [NUM_BUS-1:0][PAGE_W-1:0] core_page_i, p_page;
  bps_lock_op_t core_lock_op_i;
  logic [NUM_FLAG-1:0] flag_dir_i, flag_val_i, interrupt_flag_pin_i, interrupt_flag_pin_o;
  logic [NUM_FLAG-1:0] interrupt_flag_pin_oe_o, flag_sample_o, ext_flag;
  logic [1:0] core_tclk_i, core_tclk_oe_i;
  logic [NUM_LINK-1:0] core_link_dir_i, link_dir_o, link_port_byte_lane_oe_o;
  logic [NUM_LINK-1:0][7:0] core_link_data_i, link_port_byte_lane_o, p_ld;
  logic [NUM_LINK-1:0][LINK_LINES-1:0] core_link_hs_i, core_link_hs_oe_i, link_hs_o, link_hs_oe_o;
  logic rst_req = 1'b1;
  logic p_run, p_prim, p_interrupt_ack_out;
  logic [NUM_BUS-1:0] exp_pa, exp_pb, p_acc, p_sel, p_dd;
  int last_a [NUM_BUS];
  int last_b [NUM_BUS];
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'h3e69;

  always #10 clk_i = ~clk_i;

  bps_pin_seq i_dut (.*);
  bps_ext_model i_ext (.clk_i(clk_i), .rst_req_i(rst_req), .ext_drv_i(ext_flag), .pin_o_i(interrupt_flag_pin_o),
    .pin_oe_i(interrupt_flag_pin_oe_o), .resetn_o(resetn_i), .pin_i_o(interrupt_flag_pin_i));

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rnd_in;
    core_acc_i = 2'($random(seed));
    core_page_sel_i = 2'($random(seed));
    core_page_i = 16'($random(seed)) & 16'h0303;
    core_addr_i = 62'({$random(seed), $random(seed)});
    core_wdata_i = {$random(seed), $random(seed)};
    core_data_drive_i = 2'($random(seed));
    core_rw_i = 4'($random(seed));
    core_strb_n_i = 4'($random(seed));
    core_stat_i = 8'($random(seed));
    core_interrupt_ack_out_n_i = 1'($random(seed));
    core_tclk_i = 2'($random(seed));
    core_tclk_oe_i = 2'($random(seed));
    core_link_data_i = 48'({$random(seed), $random(seed)});
    core_link_hs_i = 24'($random(seed));
    core_link_hs_oe_i = 24'($random(seed));
    ext_flag = 4'($random(seed));
  endtask : rnd_in

  // one clock: the model steps on what was driven before the edge
  task automatic cyc(input bit rnd);
    p_run = !reset_active_o;
    p_prim = primary_phase_o;
    p_acc = core_acc_i;
    p_sel = core_page_sel_i;
    p_page = core_page_i;
    p_stat = core_stat_i;
    p_strb = core_strb_n_i;
    p_dd = core_data_drive_i;
    p_rw = core_rw_i;
    p_ld = core_link_data_i;
    p_interrupt_ack_out = core_interrupt_ack_out_n_i;
    @(posedge clk_i);
    #2;
    for (int b = 0; b < NUM_BUS; b++) begin
      if (p_run && p_prim && p_acc[b] && !p_sel[b] && p_page[b] != last_a[b]) begin
        exp_pa[b] = ~exp_pa[b];
        last_a[b] = p_page[b];
      end
      if (p_run && p_prim && p_acc[b] && p_sel[b] && p_page[b] != last_b[b]) begin
        exp_pb[b] = ~exp_pb[b];
        last_b[b] = p_page[b];
      end
    end
    chk({page_select_b_o, page_select_a_o}, {exp_pb, exp_pa}, "page select");
    if (p_run) begin
      chk({bus_read_write_o, bus_status_lines_o, bus_strobe_n_o}, {p_rw, p_stat, p_strb}, "status follow");
      chk({bus_address_lines_oe_o, bus_data_lines_oe_o}, {{NUM_BUS{1'b1}}, p_dd}, "data drive");
      chk({timer_clock_pin_b_o, timer_clock_pin_a_o, timer_clock_pin_b_oe_o, timer_clock_pin_a_oe_o},
        {core_tclk_i, core_tclk_oe_i}, "timer drive");
      chk(link_port_byte_lane_o, p_ld, "lane data");
      if (p_prim) chk(interrupt_ack_out_n_o, p_interrupt_ack_out, "interrupt_ack_out follow");
    end
    if (rnd) begin
      rnd_in();
    end
  endtask : cyc

  task automatic do_reset(input int hold);
    @(posedge clk_i);
    #2;
    rst_req = 1'b1;
    exp_pa = '0;
    exp_pb = '0;
    last_a = '{default: 0};
    last_b = '{default: 0};
    #1;
    chk({timer_clock_pin_b_oe_o, timer_clock_pin_a_oe_o, interrupt_flag_pin_oe_o}, '0, "pins float");
    chk(link_hs_oe_o, '0, "handshake float");
    chk(link_dir_o, LINK_DIR_RST, "link dir reset");
    repeat (hold) cyc(1);
    rst_req = 1'b0;
    for (int i = 0; i < 60 && !resetn_i; i++) cyc(1);
    chk(link_hs_oe_o, {{3{LINK_LOCAL_INPORT}}, {3{LINK_LOCAL_OUTPORT}}}, "local handshake");
    for (int i = 0; i < 8 && reset_active_o; i++) cyc(1);
    if (reset_active_o) begin
      err_total++;
      $display("BAD %0t reset sequence never ended", $time);
      summarize();
    end
    $display("reset test done");
  endtask : do_reset

  task automatic lk(input bps_lock_op_t op, input logic after);
    for (int i = 0; i < 4 && !primary_phase_o; i++) cyc(0);
    core_acc_i = 2'b01;
    core_lock_op_i = op;
    cyc(0);
    core_acc_i = '0;
    core_lock_op_i = BPS_OP_NONE;
    chk(bus_lock_n_o[0], 1'b0, "lock during access");
    repeat (3) cyc(0);
    chk(bus_lock_n_o[0], after, "lock after access");
  endtask : lk

  // held inputs keep the flag pins quiet while the write settles
  task automatic fl(input logic [3:0] dir, input logic [3:0] val);
    flag_dir_i = dir;
    flag_val_i = val;
    flag_we_i = 1'b1;
    cyc(0);
    flag_we_i = 1'b0;
    repeat (3) cyc(0);
    chk(interrupt_flag_pin_oe_o, dir, "flag drive");
    chk(interrupt_flag_pin_i & dir, val & dir, "flag value");
    repeat (2) cyc(0);
    chk(flag_sample_o & ~dir, ext_flag & ~dir, "flag sample");
  endtask : fl

  initial begin
    core_lock_op_i = BPS_OP_NONE;
    flag_we_i = 1'b0;
    flag_dir_i = '0;
    flag_val_i = '0;
    core_link_dir_we_i = 1'b0;
    core_link_dir_i = '0;
    rnd_in();
    do_reset(16);
    repeat (400) cyc(1);
    $display("traffic test done");
    lk(BPS_OP_LOAD, 1'b0);
    lk(BPS_OP_STORE, 1'b1);
    lk(BPS_OP_SIGNAL, 1'b1);
    $display("lock test done");
    for (int i = 0; i < 4; i++) begin
      rnd_in();
      fl(4'(15 - 5 * i), 4'($random(seed)));
    end
    $display("flag test done");
    core_link_dir_i = 6'h2c;
    core_link_dir_we_i = 1'b1;
    cyc(0);
    core_link_dir_we_i = 1'b0;
    cyc(0);
    chk({link_port_byte_lane_oe_o, link_dir_o}, {2{core_link_dir_i}}, "link dir write");
    $display("link test done");
    do_reset(4);
    repeat (50) cyc(1);
    summarize();
  end
endmodule : bps_pin_seq_tb_top
